// file: verilog/bcpc_pkg.sv
package bcpc_pkg;

  localparam int ADDR_W  = 26;
  localparam int DATA_W  = 16;
  localparam int STEP_W  = 4;
  localparam int CNT_W   = 4;
  localparam int CLK_MHZ = 40;

  // Least times round up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS    = 35;
  localparam int T_RD_NS    = 110;
  localparam int T_RECOV_NS = 30;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns2cyc(T_SETUP_NS));
  localparam logic [CNT_W-1:0] WP_CYC    = CNT_W'(ns2cyc(T_WP_NS));
  localparam logic [CNT_W-1:0] RD_CYC    = CNT_W'(ns2cyc(T_RD_NS));
  localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'(ns2cyc(T_RECOV_NS));

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h0000000;
  localparam logic [ADDR_W-1:0] UNLK1_X8  = 26'h0000AAA;
  localparam logic [ADDR_W-1:0] UNLK2_X8  = 26'h0000555;
  localparam logic [ADDR_W-1:0] UNLK1_X16 = 26'h0000555;
  localparam logic [ADDR_W-1:0] UNLK2_X16 = 26'h00002AA;

  localparam logic [7:0] D_UNLK1    = 8'hAA;
  localparam logic [7:0] D_UNLK2    = 8'h55;
  localparam logic [7:0] D_BC_SET1  = 8'hEB;
  localparam logic [7:0] D_BC_SET2  = 8'h76;
  localparam logic [7:0] D_BC_CONF  = 8'h29;
  localparam logic [7:0] D_RESET    = 8'hF0;
  localparam logic [7:0] D_EXIT1    = 8'h90;
  localparam logic [7:0] D_EXIT2    = 8'h00;
  localparam logic [7:0] D_PROG     = 8'hA0;
  localparam logic [7:0] D_BIT_SET  = 8'h00;
  localparam logic [7:0] D_BIT_CLR  = 8'h01;
  localparam logic [7:0] D_PWD_UNL1 = 8'h25;
  localparam logic [7:0] D_PWD_UNL2 = 8'h03;
  localparam logic [7:0] D_PWD_CONF = 8'h29;
  localparam logic [7:0] D_CLR_ALL1 = 8'h80;
  localparam logic [7:0] D_CLR_ALL2 = 8'h30;
  localparam logic [7:0] D_UPPER    = 8'h00;

  localparam logic [7:0] SET_LOCK_REG = 8'h40;
  localparam logic [7:0] SET_PASSWORD = 8'h60;
  localparam logic [7:0] SET_NV_PROT  = 8'hC0;
  localparam logic [7:0] SET_NV_LOCK  = 8'h50;
  localparam logic [7:0] SET_VOL_PROT = 8'hE0;

  localparam int DQ_TOGGLE_BIT = 6;
  localparam int DQ_ERR_BIT    = 5;
  localparam int DQ_PROT_BIT   = 0;

  localparam logic [STEP_W-1:0] PWD_UNITS_X8  = 4'h8;
  localparam logic [STEP_W-1:0] PWD_UNITS_X16 = 4'h4;
  localparam logic [STEP_W-1:0] PWD_FIRST     = 4'h2;

  typedef enum logic [3:0] {
    OP_BLANK      = 4'h0,
    OP_RESET      = 4'h1,
    OP_ENTER      = 4'h2,
    OP_EXIT       = 4'h3,
    OP_PROG_BIT   = 4'h4,
    OP_CLR_BIT    = 4'h5,
    OP_READ_BIT   = 4'h6,
    OP_PWD_UNLOCK = 4'h7,
    OP_CLR_ALL    = 4'h8
  } bcpc_op_t;

  typedef struct packed {
    logic              rd;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bcpc_cycle_t;

endpackage

// file: verilog/bcpc_bus_if.sv
`timescale 1ns/10ps
interface bcpc_bus_if;
  import bcpc_pkg::*;
  logic              req;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              ack;
  logic [DATA_W-1:0] rdata;

  modport ctl (output req, rd, addr, wdata, input ack, rdata);
  modport eng (input req, rd, addr, wdata, output ack, rdata);
endinterface

// file: verilog/bcpc_cycle_engine.sv
`timescale 1ns/10ps
module bcpc_cycle_engine
  import bcpc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  bcpc_bus_if.eng                bus,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_n_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o
);

  typedef enum logic [3:0] {
    E_IDLE   = 4'b0001,
    E_SETUP  = 4'b0010,
    E_STROBE = 4'b0100,
    E_RECOV  = 4'b1000
  } bcpc_est_t;

  bcpc_est_t         st, next_st;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              rd, next_rd;
  logic [DATA_W-1:0] dq, next_dq;
  logic              dq_oe_n, next_dq_oe_n;
  logic [ADDR_W-1:0] addr, next_addr;
  logic              ce_n, next_ce_n;
  logic              we_n, next_we_n;
  logic              oe_n, next_oe_n;
  logic              ack, next_ack;
  logic [DATA_W-1:0] rdata, next_rdata;

  assign dq_o      = dq;
  assign dq_oe_n_o = dq_oe_n;
  assign addr_o    = addr;
  assign ce_n_o    = ce_n;
  assign we_n_o    = we_n;
  assign oe_n_o    = oe_n;
  assign bus.ack   = ack;
  assign bus.rdata = rdata;

  always_comb
  begin
    next_st      = st;
    next_cnt     = cnt;
    next_rd      = rd;
    next_dq      = dq;
    next_dq_oe_n = dq_oe_n;
    next_addr    = addr;
    next_ce_n    = ce_n;
    next_we_n    = we_n;
    next_oe_n    = oe_n;
    next_ack     = 1'b0;
    next_rdata   = rdata;
    unique case (st)
      E_IDLE:
        if (bus.req)
        begin
          next_rd      = bus.rd;
          next_addr    = bus.addr;
          next_dq      = bus.wdata;
          next_dq_oe_n = bus.rd;
          next_ce_n    = 1'b0;
          next_cnt     = SETUP_CYC - 4'h1;
          next_st      = E_SETUP;
        end
      E_SETUP:
        if (cnt == '0)
        begin
          next_we_n = rd;
          next_oe_n = !rd;
          next_cnt  = (rd ? RD_CYC : WP_CYC) - 4'h1;
          next_st   = E_STROBE;
        end
        else
          next_cnt = cnt - 4'h1;
      E_STROBE:
        if (cnt == '0)
        begin
          // Data latches on the rising write strobe
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          if (rd)
            next_rdata = dq_i;
          next_cnt = RECOV_CYC - 4'h1;
          next_st  = E_RECOV;
        end
        else
          next_cnt = cnt - 4'h1;
      E_RECOV:
        if (cnt == '0)
        begin
          next_ce_n    = 1'b1;
          next_dq_oe_n = 1'b1;
          next_ack     = 1'b1;
          next_st      = E_IDLE;
        end
        else
          next_cnt = cnt - 4'h1;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st      <= E_IDLE;
      cnt     <= '0;
      rd      <= 1'b1;
      dq      <= '0;
      dq_oe_n <= 1'b1;
      addr    <= '0;
      ce_n    <= 1'b1;
      we_n    <= 1'b1;
      oe_n    <= 1'b1;
      ack     <= 1'b0;
      rdata   <= '0;
    end
    else if (ce_i)
    begin
      st      <= next_st;
      cnt     <= next_cnt;
      rd      <= next_rd;
      dq      <= next_dq;
      dq_oe_n <= next_dq_oe_n;
      addr    <= next_addr;
      ce_n    <= next_ce_n;
      we_n    <= next_we_n;
      oe_n    <= next_oe_n;
      ack     <= next_ack;
      rdata   <= next_rdata;
    end
  end

endmodule

// file: verilog/bcpc_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Blank check: setup command, then confirm-and-read
// - One blank check at a time, never overlapped
// - No array, program or erase during check
// - After failure issue read/reset to clear error
// - Protection commands as address/data write cycles
// - All sequence addresses and data are hexadecimal
// - Enter set first; exit set returns read
module bcpc_ctrl
  import bcpc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [3:0]        cmd_op_i,
  input  wire logic [7:0]        cmd_code_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic              byte_mode_i,
  input  wire logic [63:0]       pwd_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   blank_pass_o,
  output logic                   blank_fail_o,
  output logic                   prot_bit_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_n_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o
);

  function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] b);
    return {D_UPPER, b};
  endfunction

  function automatic bcpc_cycle_t seq_cycle(
    input bcpc_op_t          op,
    input logic [STEP_W-1:0] step,
    input logic              x8,
    input logic [ADDR_W-1:0] baddr,
    input logic [7:0]        code,
    input logic [63:0]       pwd
  );
    bcpc_cycle_t       c;
    logic [ADDR_W-1:0] u1;
    logic [ADDR_W-1:0] u2;
    logic [STEP_W-1:0] units;
    logic [2:0]        idx;
    c     = '0;
    u1    = x8 ? UNLK1_X8 : UNLK1_X16;
    u2    = x8 ? UNLK2_X8 : UNLK2_X16;
    units = x8 ? PWD_UNITS_X8 : PWD_UNITS_X16;
    idx   = 3'(step - PWD_FIRST);
    unique case (op)
      OP_BLANK:
        unique case (step)
          4'h0:    c = '{1'b0, 1'b0, u1, cmd_word(D_BC_SET1)};
          4'h1:    c = '{1'b0, 1'b0, u2, cmd_word(D_BC_SET2)};
          default: c = '{1'b0, 1'b1, baddr, cmd_word(D_BC_CONF)};
        endcase
      OP_RESET:
        c = '{1'b0, 1'b1, ADDR_ZERO, cmd_word(D_RESET)};
      OP_ENTER:
        unique case (step)
          4'h0:    c = '{1'b0, 1'b0, u1, cmd_word(D_UNLK1)};
          4'h1:    c = '{1'b0, 1'b0, u2, cmd_word(D_UNLK2)};
          default: c = '{1'b0, 1'b1, u1, cmd_word(code)};
        endcase
      OP_EXIT:
        if (step == '0)
          c = '{1'b0, 1'b0, ADDR_ZERO, cmd_word(D_EXIT1)};
        else
          c = '{1'b0, 1'b1, ADDR_ZERO, cmd_word(D_EXIT2)};
      OP_PROG_BIT, OP_CLR_BIT:
        if (step == '0)
          c = '{1'b0, 1'b0, ADDR_ZERO, cmd_word(D_PROG)};
        else
          c = '{1'b0, 1'b1, baddr,
                cmd_word(op == OP_CLR_BIT ? D_BIT_CLR : D_BIT_SET)};
      OP_READ_BIT:
        c = '{1'b1, 1'b1, baddr, '0};
      OP_CLR_ALL:
        if (step == '0)
          c = '{1'b0, 1'b0, ADDR_ZERO, cmd_word(D_CLR_ALL1)};
        else
          c = '{1'b0, 1'b1, ADDR_ZERO, cmd_word(D_CLR_ALL2)};
      OP_PWD_UNLOCK:
        if (step == 4'h0)
          c = '{1'b0, 1'b0, ADDR_ZERO, cmd_word(D_PWD_UNL1)};
        else if (step == 4'h1)
          c = '{1'b0, 1'b0, ADDR_ZERO, cmd_word(D_PWD_UNL2)};
        else if (step < units + PWD_FIRST)
          c = '{1'b0, 1'b0, {23'h000000, idx},
                x8 ? cmd_word(pwd[idx*8 +: 8])
                   : pwd[idx[1:0]*16 +: 16]};
        else
          c = '{1'b0, 1'b1, ADDR_ZERO, cmd_word(D_PWD_CONF)};
      default:
        c = '{1'b0, 1'b1, ADDR_ZERO, cmd_word(D_RESET)};
    endcase
    return c;
  endfunction

  typedef enum logic [2:0] {
    M_IDLE  = 3'b001,
    M_ISSUE = 3'b010,
    M_WAIT  = 3'b100
  } bcpc_mst_t;

  bcpc_mst_t         st, next_st;
  bcpc_op_t          op, next_op;
  logic [STEP_W-1:0] step, next_step;
  logic              x8, next_x8;
  logic [ADDR_W-1:0] baddr, next_baddr;
  logic [7:0]        code, next_code;
  logic [63:0]       pwd, next_pwd;
  logic              polling, next_polling;
  logic              first, next_first;
  logic [DATA_W-1:0] prev, next_prev;
  logic              busy, next_busy;
  logic              done, next_done;
  logic              pass, next_pass;
  logic              fail, next_fail;
  logic              pbit, next_pbit;
  logic              req, next_req;
  bcpc_cycle_t       cyc;
  logic              toggling;

  bcpc_bus_if bus ();

  assign cyc       = seq_cycle(op, step, x8, baddr, code, pwd);
  assign bus.req   = req;
  // Polling reads may go to any address; the block address is reused
  assign bus.rd    = polling | cyc.rd;
  assign bus.addr  = polling ? baddr : cyc.addr;
  assign bus.wdata = cyc.data;
  assign toggling  = prev[DQ_TOGGLE_BIT] != bus.rdata[DQ_TOGGLE_BIT];

  assign busy_o       = busy;
  assign done_o       = done;
  assign blank_pass_o = pass;
  assign blank_fail_o = fail;
  assign prot_bit_o   = pbit;

  always_comb
  begin
    next_st      = st;
    next_op      = op;
    next_step    = step;
    next_x8      = x8;
    next_baddr   = baddr;
    next_code    = code;
    next_pwd     = pwd;
    next_polling = polling;
    next_first   = first;
    next_prev    = prev;
    next_busy    = busy;
    next_done    = 1'b0;
    next_pass    = pass;
    next_fail    = fail;
    next_pbit    = pbit;
    next_req     = 1'b0;
    unique case (st)
      M_IDLE:
        // Busy blocks new commands, so checks never overlap
        if (cmd_valid_i && !busy)
        begin
          next_op      = bcpc_op_t'(cmd_op_i);
          next_code    = cmd_code_i;
          next_baddr   = cmd_addr_i;
          next_x8      = byte_mode_i;
          next_pwd     = pwd_i;
          next_step    = '0;
          next_polling = 1'b0;
          next_busy    = 1'b1;
          if (bcpc_op_t'(cmd_op_i) == OP_BLANK)
          begin
            next_pass = 1'b0;
            next_fail = 1'b0;
          end
          next_req = 1'b1;
          next_st  = M_ISSUE;
        end
      M_ISSUE:
        next_st = M_WAIT;
      M_WAIT:
        if (bus.ack)
        begin
          next_req = 1'b1;
          next_st  = M_ISSUE;
          if (polling && first)
          begin
            next_prev  = bus.rdata;
            next_first = 1'b0;
          end
          else if (polling && !toggling)
          begin
            // Status stopped toggling: device back in array read
            next_pass    = 1'b1;
            next_polling = 1'b0;
            next_busy    = 1'b0;
            next_done    = 1'b1;
            next_req     = 1'b0;
            next_st      = M_IDLE;
          end
          // Error needs DQ5 in two reads: finished array data may show it once
          else if (polling && bus.rdata[DQ_ERR_BIT] && prev[DQ_ERR_BIT])
          begin
            // Device holds the status word until reset
            next_fail    = 1'b1;
            next_polling = 1'b0;
            next_op      = OP_RESET;
            next_step    = '0;
          end
          else if (polling)
            next_prev = bus.rdata;
          else if (!cyc.last)
            next_step = step + 4'h1;
          else if (op == OP_BLANK)
          begin
            next_polling = 1'b1;
            next_first   = 1'b1;
          end
          else
          begin
            if (op == OP_READ_BIT)
              next_pbit = bus.rdata[DQ_PROT_BIT];
            next_busy = 1'b0;
            next_done = 1'b1;
            next_req  = 1'b0;
            next_st   = M_IDLE;
          end
        end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st      <= M_IDLE;
      op      <= OP_RESET;
      step    <= '0;
      x8      <= 1'b0;
      baddr   <= '0;
      code    <= '0;
      pwd     <= '0;
      polling <= 1'b0;
      first   <= 1'b0;
      prev    <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
      pass    <= 1'b0;
      fail    <= 1'b0;
      pbit    <= 1'b0;
      req     <= 1'b0;
    end
    else if (ce_i)
    begin
      st      <= next_st;
      op      <= next_op;
      step    <= next_step;
      x8      <= next_x8;
      baddr   <= next_baddr;
      code    <= next_code;
      pwd     <= next_pwd;
      polling <= next_polling;
      first   <= next_first;
      prev    <= next_prev;
      busy    <= next_busy;
      done    <= next_done;
      pass    <= next_pass;
      fail    <= next_fail;
      pbit    <= next_pbit;
      req     <= next_req;
    end
  end

  bcpc_cycle_engine u_engine (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .bus       (bus),
    .dq_i      (dq_i),
    .dq_o      (dq_o),
    .dq_oe_n_o (dq_oe_n_o),
    .addr_o    (addr_o),
    .ce_n_o    (ce_n_o),
    .we_n_o    (we_n_o),
    .oe_n_o    (oe_n_o)
  );

endmodule

// file: tb/bcpc_ctrl_monitor.sv
`timescale 1ns/10ps
module bcpc_ctrl_monitor
  import bcpc_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              resetn_i,
  input wire logic              ce_i,
  input wire logic              cmd_valid_i,
  input wire logic              byte_mode_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire logic              blank_pass_o,
  input wire logic              blank_fail_o,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe_n_o,
  input wire logic              ce_n_o,
  input wire logic              we_n_o,
  input wire logic              oe_n_o
);
  default clocking mon_clk @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence reset_write_s;
    !we_n_o && !dq_oe_n_o && dq_o[7:0] == D_RESET;
  endsequence
  sequence finish_s;
    done_o && !busy_o;
  endsequence

  strobe_excl_a: assert property (we_n_o || oe_n_o)
    else $error("write and read strobes low together");
  write_drive_a: assert property (!we_n_o |-> !ce_n_o && !dq_oe_n_o)
    else $error("write strobe without select or data drive");
  read_float_a: assert property (!oe_n_o |-> dq_oe_n_o)
    else $error("data driven during a read");
  upper_zero_a: assert property (
    byte_mode_i && !dq_oe_n_o |-> dq_o[15:8] == D_UPPER)
    else $error("upper data byte not zero");
  we_pulse_a: assert property (disable iff (!resetn_i || !ce_i)
    $fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o)
    else $error("write pulse not two cycles");
  done_pulse_a: assert property (disable iff (!resetn_i || !ce_i)
    done_o && $past(ce_i) |-> !busy_o && $past(busy_o) ##1 !done_o)
    else $error("done not a single pulse at busy fall");
  flags_excl_a: assert property (!(blank_pass_o && blank_fail_o))
    else $error("pass and fail flags both set");
  fail_clear_a: assert property (disable iff (!resetn_i || !ce_i)
    $rose(blank_fail_o) |-> ##[0:40] reset_write_s ##[1:40] finish_s)
    else $error("failed check not cleared by reset write");
  pass_done_a: assert property (disable iff (!resetn_i || !ce_i)
    $rose(blank_pass_o) |-> ##[0:2] finish_s)
    else $error("passing check did not complete");
  take_cmd_a: assert property (
    cmd_valid_i && ce_i && !busy_o && !done_o |=> busy_o)
    else $error("idle command not taken");
  ce_freeze_a: assert property (!ce_i |=> $stable({busy_o, done_o, we_n_o,
    oe_n_o, ce_n_o, dq_o}))
    else $error("outputs moved while clock enable low");
endmodule

bind bcpc_ctrl bcpc_ctrl_monitor mon (
  .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .cmd_valid_i(cmd_valid_i), .byte_mode_i(byte_mode_i),
  .busy_o(busy_o), .done_o(done_o), .blank_pass_o(blank_pass_o),
  .blank_fail_o(blank_fail_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
  .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o));

// file: tb/bcpc_flash_model.sv
`timescale 1ns/10ps
module bcpc_flash_model
  import bcpc_pkg::*;
#(
  parameter logic [63:0] PWD = 64'h0F1E2D3C4B5A6978
)
(
  input  wire logic              ce_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              byte_mode_i,
  input  wire logic [3:0]        check_len_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   in_check_o = 1'b0,
  output logic                   err_o = 1'b0,
  output logic                   set_mode_o = 1'b0,
  output logic                   pwd_ok_o = 1'b0,
  output logic      [7:0]        checks_o = 8'h00
);
  // Block index taken from A25..A16 in both bus widths
  logic [1023:0]     prot = '0;
  logic [7:0]        p1 = 8'h00;
  logic [7:0]        p2 = 8'h00;
  logic [7:0]        d;
  logic [3:0]        reads = 4'h0;
  logic [3:0]        pw_n = 4'h0;
  logic              tog = 1'b0;
  logic              pw_on = 1'b0;
  logic              pw_good;
  logic              blank;
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] unit;

  always @(posedge we_n_i)
  begin
    if (!ce_n_i)
    begin
      d = data_i[7:0];
      unit = byte_mode_i ? {8'h00, PWD[8*addr_i[2:0] +: 8]}
                         : PWD[16*addr_i[1:0] +: 16];
      if (pw_on)
      begin
        if (pw_n == (byte_mode_i ? PWD_UNITS_X8 : PWD_UNITS_X16))
        begin
          pwd_ok_o = pw_good && d == D_PWD_CONF;
          pw_on = 1'b0;
        end
        else
        begin
          pw_good = pw_good && addr_i[3:0] == pw_n && data_i == unit;
          pw_n = pw_n + 4'h1;
        end
      end
      else if (d == D_RESET)
      begin
        in_check_o = 1'b0;
        err_o = 1'b0;
      end
      else if (p2 == D_BC_SET1 && p1 == D_BC_SET2 && d == D_BC_CONF
               && !in_check_o)
      begin
        in_check_o = 1'b1;
        blank = !addr_i[16];
        reads = 4'h0;
        checks_o = checks_o + 8'h01;
      end
      else if (p2 == D_UNLK1 && p1 == D_UNLK2)
        set_mode_o = 1'b1;
      else if (p1 == D_EXIT1 && d == D_EXIT2)
        set_mode_o = 1'b0;
      else if (p1 == D_PROG && set_mode_o)
        prot[addr_i[25:16]] = (d == D_BIT_SET);
      else if (p1 == D_CLR_ALL1 && d == D_CLR_ALL2)
        prot = '0;
      else if (p1 == D_PWD_UNL1 && d == D_PWD_UNL2)
      begin
        pw_on = 1'b1;
        pw_good = 1'b1;
        pw_n = 4'h0;
      end
      p2 = p1;
      p1 = d;
    end
  end

  always @(negedge oe_n_i)
  begin
    if (!ce_n_i && in_check_o)
    begin
      tog = ~tog;
      reads = reads + 4'h1;
      if (!err_o && reads >= check_len_i)
      begin
        in_check_o = !blank;
        err_o = !blank;
      end
    end
  end

  // A released bus shows the inverse of the last value, never a held copy
  always @(posedge oe_n_i)
    last = data_o;

  always_comb
    data_o = oe_n_i ? ~last
           : in_check_o ? {9'h000, tog, err_o, 5'h00}
           : set_mode_o ? {15'h0000, prot[addr_i[25:16]]}
           : 16'hFFFF;
endmodule

// file: tb/blank_check_and_protection_commands_test.sv
`timescale 1ns/10ps
module blank_check_and_protection_commands_test
  import bcpc_pkg::*;
;
  localparam logic [63:0] PWD = 64'h0F1E2D3C4B5A6978;
  logic              clock_i = 1'b0;
  logic              resetn_i = 1'b0;
  logic              ce_i = 1'b1;
  logic              cmd_valid_i = 1'b0;
  logic [3:0]        cmd_op_i = 4'h0;
  logic [7:0]        cmd_code_i = 8'h00;
  logic [ADDR_W-1:0] cmd_addr_i = '0;
  logic              byte_mode_i = 1'b0;
  logic [63:0]       pwd_i = PWD;
  logic [3:0]        check_len = 4'h1;
  logic              stall = 1'b0;
  logic [DATA_W-1:0] dq_i, dq_o;
  logic [ADDR_W-1:0] addr_o, a;
  logic              busy_o, done_o, blank_pass_o, blank_fail_o, prot_bit_o;
  logic              dq_oe_n_o, ce_n_o, we_n_o, oe_n_o;
  logic              in_check, err, set_mode, pwd_ok;
  logic [7:0]        checks, cnt;
  logic [7:0]        codes [5];
  int                seed = 32'h208d;
  int                n_errors = 0;
  int                n_tests = 0;

  bcpc_ctrl DUT (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_code_i(cmd_code_i),
    .cmd_addr_i(cmd_addr_i), .byte_mode_i(byte_mode_i), .pwd_i(pwd_i),
    .busy_o(busy_o), .done_o(done_o), .blank_pass_o(blank_pass_o),
    .blank_fail_o(blank_fail_o), .prot_bit_o(prot_bit_o), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .addr_o(addr_o), .ce_n_o(ce_n_o),
    .we_n_o(we_n_o), .oe_n_o(oe_n_o));

  bcpc_flash_model #(.PWD(PWD)) FLASH (.ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .addr_i(addr_o), .data_i(dq_o),
    .byte_mode_i(byte_mode_i), .check_len_i(check_len), .data_o(dq_i),
    .in_check_o(in_check), .err_o(err), .set_mode_o(set_mode),
    .pwd_ok_o(pwd_ok), .checks_o(checks));

  always #12.5 clock_i = ~clock_i;

  // Random clock-enable gaps stretch the bus cycles once stall is set, from the protection commands on
  always @(negedge clock_i)
    ce_i <= stall ? ($random(seed) % 4 != 0) : 1'b1;

  // The model keeps blocks with A16 clear erased
  function automatic logic exp_blank(input logic [ADDR_W-1:0] ba);
    return !ba[16];
  endfunction

  task automatic check_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_count(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_cmd(input logic [3:0] op, input logic [7:0] code,
                         input logic [ADDR_W-1:0] ba);
    int k;
    @(negedge clock_i);
    cmd_op_i = op;
    cmd_code_i = code;
    cmd_addr_i = ba;
    cmd_valid_i = 1'b1;
    k = 0;
    do @(negedge clock_i); while (busy_o !== 1'b1 && ++k < 50);
    cmd_valid_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 4000)
    begin
      @(negedge clock_i);
      k++;
    end
    check_flag(done_o, 1'b1);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #1500000;
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (10) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      a = $random(seed);
      a[16] = i[0];
      byte_mode_i = $random(seed);
      check_len = (i < 2) ? 4'h1 : 4'(($random(seed) & 7) + 1);
      cnt = checks;
      run_cmd(OP_BLANK, 8'h00, a);
      check_count(checks, cnt + 8'h01);
      check_flag(blank_pass_o, exp_blank(a));
      check_flag(blank_fail_o, !exp_blank(a));
      check_flag(in_check | err, 1'b0);
    end
    resetn_i = 1'b0;
    repeat (2) @(negedge clock_i);
    resetn_i = 1'b1;
    check_flag(blank_pass_o | blank_fail_o, 1'b0);
    run_cmd(4'hF, 8'h00, '0);
    stall = 1'b1;
    codes = '{SET_LOCK_REG, SET_PASSWORD, SET_NV_PROT, SET_NV_LOCK,
              SET_VOL_PROT};
    foreach (codes[j])
    begin
      byte_mode_i = $random(seed);
      a = $random(seed);
      run_cmd(OP_ENTER, codes[j], '0);
      run_cmd(OP_RESET, 8'h00, '0);
      check_flag(set_mode, 1'b1);
      run_cmd(OP_PROG_BIT, 8'h00, a);
      run_cmd(OP_READ_BIT, 8'h00, a);
      check_flag(prot_bit_o, 1'b1);
      run_cmd(j % 2 ? OP_CLR_ALL : OP_CLR_BIT, 8'h00, a);
      run_cmd(OP_READ_BIT, 8'h00, a);
      check_flag(prot_bit_o, 1'b0);
      run_cmd(OP_EXIT, 8'h00, '0);
      check_flag(set_mode, 1'b0);
    end
    for (int i = 0; i < 4; i++)
    begin
      byte_mode_i = i[0];
      pwd_i = i[1] ? PWD ^ (64'h1 << ($random(seed) & 63)) : PWD;
      run_cmd(OP_PWD_UNLOCK, 8'h00, '0);
      check_flag(pwd_ok, !i[1]);
    end
    summarize();
  end
endmodule
